// ===== shared/arith_decode_pkg.sv
// Package with opcode codes, field positions and clock counts for the decoder.
package arith_decode_pkg;

	// ==================================================================
	// Opcode bytes and masks.
	// ==================================================================
	localparam logic [7:0] OPC_UNPACKED_ADD_ADJUST = 8'h37; // 00110111.
	localparam logic [7:0] OPC_PACKED_ADD_ADJUST   = 8'h27; // 00100111.
	localparam logic [7:0] OPC_UNPACKED_SUB_ADJUST = 8'h3F; // 00111111.
	localparam logic [7:0] OPC_PACKED_SUB_ADJUST   = 8'h2F; // 00101111.
	localparam logic [7:0] OPC_GROUP_MASK          = 8'hFE; // Ignores w.
	localparam logic [7:0] OPC_GROUP_MULDIV        = 8'hF6; // 1111011w.
	localparam logic [7:0] OPC_IMM_MUL_MASK        = 8'hFD; // Ignores s.
	localparam logic [7:0] OPC_IMM_MUL             = 8'h69; // 011010s1.

	// ==================================================================
	// Field positions in the opcode and the second byte.
	// ==================================================================
	localparam int         SIZE_BIT     = 0; // w: 0 byte, 1 word.
	localparam int         SIGN_EXT_BIT = 1; // s: 1 means one data byte.
	localparam int         MOD_HI       = 7; // Mode field, upper bit.
	localparam int         MOD_LO       = 6; // Mode field, lower bit.
	localparam int         SUBOP_HI     = 5; // Middle field, upper bit.
	localparam int         SUBOP_LO     = 3; // Middle field, lower bit.
	localparam logic [1:0] MOD_REGISTER = 2'h3; // Mode for a register.

	// ==================================================================
	// Sub-opcodes in the middle field of the second byte.
	// ==================================================================
	localparam logic [2:0] SUBOP_UNSIGNED_MULTIPLY = 3'h4; // 100.
	localparam logic [2:0] SUBOP_SIGNED_MULTIPLY   = 3'h5; // 101.
	localparam logic [2:0] SUBOP_UNSIGNED_DIVIDE   = 3'h6; // 110.

	// ==================================================================
	// Execution clock counts, in processor clocks.
	// ==================================================================
	localparam int         CNT_W = 5; // Width of the countdown.
	localparam logic [4:0] CLK_ADJUST        = 5'h03; // 3.
	localparam logic [4:0] CLK_MUL_REG_BYTE  = 5'h0D; // 13.
	localparam logic [4:0] CLK_MUL_REG_WORD  = 5'h15; // 21.
	localparam logic [4:0] CLK_MUL_MEM_BYTE  = 5'h10; // 16.
	localparam logic [4:0] CLK_MUL_MEM_WORD  = 5'h18; // 24.
	localparam logic [4:0] CLK_IMM_MUL_REG   = 5'h15; // 21.
	localparam logic [4:0] CLK_IMM_MUL_MEM   = 5'h18; // 24.
	localparam logic [4:0] CLK_DIV_REG_BYTE  = 5'h0E; // 14.
	localparam logic [4:0] CLK_DIV_REG_WORD  = 5'h16; // 22.
	localparam logic [4:0] CLK_DIV_MEM_BYTE  = 5'h11; // 17.
	localparam logic [4:0] CLK_DIV_MEM_WORD  = 5'h19; // 25.

	// ==================================================================
	// Operation reported on the output port.
	// ==================================================================
	typedef enum logic [3:0] {
		OP_NONE,
		OP_UNPACKED_ADD_ADJUST,
		OP_PACKED_ADD_ADJUST,
		OP_UNPACKED_SUB_ADJUST,
		OP_PACKED_SUB_ADJUST,
		OP_UNSIGNED_MULTIPLY,
		OP_SIGNED_MULTIPLY,
		OP_SIGNED_MULTIPLY_IMM,
		OP_UNSIGNED_DIVIDE
	} op_e;

endpackage : arith_decode_pkg

// ===== rtl/clock_countdown.sv
// Countdown that times the execution phase of one instruction.
`timescale 1ns/1ps

module clock_countdown
	import arith_decode_pkg::*;
(
	input  wire logic                               sys_clk_i,  // Clock.
	input  wire logic                               sys_rst_i,  // Reset.
	input  wire logic                               load_i,     // Start.
	input  wire logic [arith_decode_pkg::CNT_W-1:0] load_val_i, // Clocks.
	output logic                                    last_o      // Final.
);

	// ==================================================================
	// State.
	// ==================================================================
	typedef struct packed {
		logic [CNT_W-1:0] remain; // Clocks still to run.
	} count_s;

	count_s cnt_reg;  // Registered state.
	count_s cnt_next; // Next state.

	// Loads the count, or steps it down towards zero.
	always_comb
	begin
		cnt_next = cnt_reg;
		if (load_i)
		begin
			cnt_next.remain = load_val_i;
		end
		else if (cnt_reg.remain != '0)
		begin
			cnt_next.remain = cnt_reg.remain - 1'b1;
		end
	end

	// Registers the count; reset leaves it idle at zero.
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			cnt_reg <= '0;
		end
		else
		begin
			cnt_reg <= cnt_next;
		end
	end

	// The last clock of the run is the one where a single clock remains.
	assign last_o = (cnt_reg.remain == {{(CNT_W-1){1'b0}}, 1'b1});

endmodule : clock_countdown

// ===== rtl/arith_opcode_decode_timing.sv
// Decoder and execution timer for adjust, multiply and divide instructions.
// Function
// - 00110111 is unpacked add adjust, 3 clocks.
// - 00100111 is packed add adjust, 3 clocks.
// - 00111111 is unpacked subtract adjust, 3 clocks.
// - 00101111 is packed subtract adjust, 3 clocks.
// - Sub-opcode 100 unsigned multiply: 13/21/16/24 clocks.
// - Sub-opcode 101 signed multiply: same clock counts.
// - Immediate signed multiply, 21 register, 24 memory.
// - Sub-opcode 110 unsigned divide, byte register 14.
`timescale 1ns/1ps

module arith_opcode_decode_timing
	import arith_decode_pkg::*;
(
	input  wire logic                 sys_clk_i,    // 200 MHz clock.
	input  wire logic                 sys_rst_i,    // Synchronous reset.
	input  wire logic                 byte_valid_i, // Byte offered.
	input  wire logic [7:0]           byte_i,       // Instruction byte.
	output logic                      byte_ready_o, // Byte may be taken.
	output logic                      busy_o,       // Executing.
	output logic                      done_o,       // Execution finished.
	output logic                      reject_o,     // Unknown opcode.
	output arith_decode_pkg::op_e     op_o,         // Decoded operation.
	output logic                      word_o,       // Word operand size.
	output logic                      mem_o         // Memory operand.
);

	// ==================================================================
	// Types and state.
	// ==================================================================
	// Decode phases: opcode, second byte, immediate data, execution.
	typedef enum logic [1:0] {
		PH_OPCODE,
		PH_MODRM,
		PH_IMMEDIATE,
		PH_EXECUTE
	} phase_e;

	// Complete state of the decoder; every output is one of its fields.
	typedef struct packed {
		phase_e     phase;    // Current decode phase.
		op_e        op;       // Operation being decoded or executed.
		logic       word;     // Operand size, 1 for word.
		logic       mem;      // Operand lies in memory.
		logic [1:0] imm_left; // Immediate bytes still to take.
		logic       ready;    // Next byte may be taken.
		logic       busy;     // Execution is running.
		logic       done;     // One-clock completion pulse.
		logic       reject;   // One-clock unknown opcode pulse.
	} dec_s;

	dec_s             st_reg;    // Registered state.
	dec_s             st_next;   // Next state.
	logic             accept;    // A byte is taken this clock.
	logic             cnt_load;  // Starts the execution countdown.
	logic [CNT_W-1:0] cnt_value; // Clocks loaded into the countdown.
	logic             cnt_last;  // Countdown is on its final clock.

	// ==================================================================
	// Clock count lookup.
	// ==================================================================
	// Returns the execution clocks for an operation, size and location.
	function automatic logic [CNT_W-1:0] exec_clocks(
		input op_e  op,
		input logic word,
		input logic mem
	);
		logic [CNT_W-1:0] clocks;
		clocks = CLK_ADJUST;
		case (op)
			OP_UNSIGNED_MULTIPLY, OP_SIGNED_MULTIPLY:
			begin
				// Both multiply forms share one table.
				case ({mem, word})
					2'h0:    clocks = CLK_MUL_REG_BYTE;
					2'h1:    clocks = CLK_MUL_REG_WORD;
					2'h2:    clocks = CLK_MUL_MEM_BYTE;
					default: clocks = CLK_MUL_MEM_WORD;
				endcase
			end
			OP_SIGNED_MULTIPLY_IMM:
			begin
				// Only the operand location changes the count.
				clocks = mem ? CLK_IMM_MUL_MEM : CLK_IMM_MUL_REG;
			end
			OP_UNSIGNED_DIVIDE:
			begin
				// Divide counts differ in every case.
				case ({mem, word})
					2'h0:    clocks = CLK_DIV_REG_BYTE;
					2'h1:    clocks = CLK_DIV_REG_WORD;
					2'h2:    clocks = CLK_DIV_MEM_BYTE;
					default: clocks = CLK_DIV_MEM_WORD;
				endcase
			end
			default:
			begin
				// Adjust operations always take the short count.
				clocks = CLK_ADJUST;
			end
		endcase
		return clocks;
	endfunction : exec_clocks

	// ==================================================================
	// Countdown for the execution phase.
	// ==================================================================
	// Counts the execution clocks and flags the final one.
	clock_countdown u_countdown (
		.sys_clk_i  (sys_clk_i),
		.sys_rst_i  (sys_rst_i),
		.load_i     (cnt_load),
		.load_val_i (cnt_value),
		.last_o     (cnt_last)
	);

	// ==================================================================
	// Decode and sequencing.
	// ==================================================================
	// A byte is taken only while the decoder shows itself ready.
	assign accept = st_reg.ready & byte_valid_i;

	// Walks through the bytes of an instruction, then times its execution.
	always_comb
	begin
		st_next        = st_reg;
		st_next.done   = 1'b0;
		st_next.reject = 1'b0;
		cnt_load       = 1'b0;
		cnt_value      = '0;
		case (st_reg.phase)
			PH_OPCODE:
			begin
				// First byte: single-byte adjusts start at once.
				if (accept)
				begin
					st_next.word = 1'b0;
					st_next.mem  = 1'b0;
					if (byte_i == OPC_UNPACKED_ADD_ADJUST)
					begin
						st_next.op = OP_UNPACKED_ADD_ADJUST;
					end
					else if (byte_i == OPC_PACKED_ADD_ADJUST)
					begin
						st_next.op = OP_PACKED_ADD_ADJUST;
					end
					else if (byte_i == OPC_UNPACKED_SUB_ADJUST)
					begin
						st_next.op = OP_UNPACKED_SUB_ADJUST;
					end
					else if (byte_i == OPC_PACKED_SUB_ADJUST)
					begin
						st_next.op = OP_PACKED_SUB_ADJUST;
					end
					else if ((byte_i & OPC_GROUP_MASK) == OPC_GROUP_MULDIV)
					begin
						// Sub-opcode is still unknown.
						st_next.op    = OP_NONE;
						st_next.word  = byte_i[SIZE_BIT];
						st_next.phase = PH_MODRM;
					end
					else if ((byte_i & OPC_IMM_MUL_MASK) == OPC_IMM_MUL)
					begin
						// One data byte when s is set, two otherwise.
						st_next.op       = OP_SIGNED_MULTIPLY_IMM;
						st_next.word     = 1'b1;
						st_next.imm_left = byte_i[SIGN_EXT_BIT] ?
							2'h1 : 2'h2;
						st_next.phase    = PH_MODRM;
					end
					else
					begin
						// Outside this group: refuse and stay idle.
						st_next.op     = OP_NONE;
						st_next.reject = 1'b1;
					end
					// Adjust operations go straight to execution.
					if (st_next.op != OP_NONE && st_next.phase == PH_OPCODE)
					begin
						cnt_load      = 1'b1;
						cnt_value     = CLK_ADJUST;
						st_next.busy  = 1'b1;
						st_next.phase = PH_EXECUTE;
					end
				end
			end
			PH_MODRM:
			begin
				// Second byte: location and, for the group, the sub-opcode.
				if (accept)
				begin
					st_next.mem = (byte_i[MOD_HI:MOD_LO] != MOD_REGISTER);
					if (st_reg.op == OP_SIGNED_MULTIPLY_IMM)
					begin
						st_next.phase = PH_IMMEDIATE;
					end
					else
					begin
						case (byte_i[SUBOP_HI:SUBOP_LO])
							SUBOP_UNSIGNED_MULTIPLY:
								st_next.op = OP_UNSIGNED_MULTIPLY;
							SUBOP_SIGNED_MULTIPLY:
								st_next.op = OP_SIGNED_MULTIPLY;
							SUBOP_UNSIGNED_DIVIDE:
								st_next.op = OP_UNSIGNED_DIVIDE;
							default:
								st_next.op = OP_NONE;
						endcase
						if (st_next.op == OP_NONE)
						begin
							// Other sub-opcodes are not handled here.
							st_next.reject = 1'b1;
							st_next.phase  = PH_OPCODE;
						end
						else
						begin
							cnt_load      = 1'b1;
							cnt_value     = exec_clocks(st_next.op,
								st_next.word, st_next.mem);
							st_next.busy  = 1'b1;
							st_next.phase = PH_EXECUTE;
						end
					end
				end
			end
			PH_IMMEDIATE:
			begin
				// Immediate data bytes; execution starts after the last.
				if (accept)
				begin
					st_next.imm_left = st_reg.imm_left - 2'h1;
					if (st_reg.imm_left == 2'h1)
					begin
						cnt_load      = 1'b1;
						cnt_value     = exec_clocks(st_reg.op, st_reg.word,
							st_reg.mem);
						st_next.busy  = 1'b1;
						st_next.phase = PH_EXECUTE;
					end
				end
			end
			PH_EXECUTE:
			begin
				// Final counted clock ends the run with a done pulse.
				if (cnt_last)
				begin
					st_next.busy  = 1'b0;
					st_next.done  = 1'b1;
					st_next.phase = PH_OPCODE;
				end
			end
			default:
			begin
				// Unreachable encoding: recover to the idle phase.
				st_next.phase = PH_OPCODE;
				st_next.busy  = 1'b0;
			end
		endcase
		// Bytes are refused only while an instruction executes.
		st_next.ready = (st_next.phase != PH_EXECUTE);
	end

	// Registers the state; reset leaves the decoder idle and ready.
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			st_reg          <= '0;
			st_reg.phase    <= PH_OPCODE;
			st_reg.op       <= OP_NONE;
			st_reg.ready    <= 1'b1;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// ==================================================================
	// Outputs, each taken from the registered state.
	// ==================================================================
	assign byte_ready_o = st_reg.ready;
	assign busy_o       = st_reg.busy;
	assign done_o       = st_reg.done;
	assign reject_o     = st_reg.reject;
	assign op_o         = st_reg.op;
	assign word_o       = st_reg.word;
	assign mem_o        = st_reg.mem;

endmodule : arith_opcode_decode_timing

// ===== tb/arith_decode_checker_assertions.sv
// Checker of busy lengths and handshakes for the arithmetic decoder.
`timescale 1ns/1ps

module arith_decode_checker
	import arith_decode_pkg::*;
(
	input wire logic                  sys_clk_i,    // Clock.
	input wire logic                  sys_rst_i,    // Reset.
	input wire logic                  byte_ready_o, // Byte may be taken.
	input wire logic                  busy_o,       // Executing.
	input wire logic                  done_o,       // Finished pulse.
	input wire logic                  reject_o,     // Reject pulse.
	input wire arith_decode_pkg::op_e op_o,         // Operation.
	input wire logic                  word_o,       // Word size.
	input wire logic                  mem_o         // Memory operand.
);
	// ==================================================================
	// Busy length counter.
	// ==================================================================
	logic [4:0] len_reg; // Cycles spent busy so far.
	logic [4:0] mul_len; // Length a multiply must take.

	assign mul_len = mem_o ? (word_o ? CLK_MUL_MEM_WORD : CLK_MUL_MEM_BYTE)
		: (word_o ? CLK_MUL_REG_WORD : CLK_MUL_REG_BYTE);

	// The count clears whenever the decoder is not executing.
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i || !busy_o)
			len_reg <= 5'h00;
		else
			len_reg <= len_reg + 5'h01;
	end

	// ==================================================================
	// Assertions.
	// ==================================================================
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	a_ready_while_busy: assert property (busy_o |-> !byte_ready_o)
		else $error("byte ready while busy");
	a_done_after_busy: assert property ($fell(busy_o) |-> done_o)
		else $error("no done after busy");
	a_done_one_pulse: assert property (done_o |-> !busy_o ##1 !done_o)
		else $error("done not a single pulse");
	a_adjust_length: assert property (
		$fell(busy_o) && op_o inside {OP_UNPACKED_ADD_ADJUST,
		OP_PACKED_ADD_ADJUST, OP_UNPACKED_SUB_ADJUST, OP_PACKED_SUB_ADJUST}
		|-> len_reg == CLK_ADJUST && !word_o && !mem_o)
		else $error("adjust length wrong");
	a_multiply_length: assert property (
		$fell(busy_o) && op_o inside {OP_UNSIGNED_MULTIPLY,
		OP_SIGNED_MULTIPLY} |-> len_reg == mul_len)
		else $error("multiply length wrong");
	a_imm_length: assert property ($fell(busy_o) &&
		op_o == OP_SIGNED_MULTIPLY_IMM |-> word_o &&
		len_reg == (mem_o ? CLK_IMM_MUL_MEM : CLK_IMM_MUL_REG))
		else $error("immediate multiply length wrong");
	a_divide_length: assert property ($fell(busy_o) &&
		op_o == OP_UNSIGNED_DIVIDE && !word_o && !mem_o |->
		len_reg == CLK_DIV_REG_BYTE)
		else $error("divide length wrong");
	a_reject_idle: assert property (reject_o |->
		!busy_o && op_o == OP_NONE ##1 !reject_o)
		else $error("reject while not idle");
endmodule : arith_decode_checker

bind arith_opcode_decode_timing arith_decode_checker u_arith_decode_checker (
	.sys_clk_i, .sys_rst_i, .byte_ready_o, .busy_o, .done_o, .reject_o,
	.op_o, .word_o, .mem_o);

// ===== tb/arith_opcode_decode_timing_tb_top.sv
// Self-checking bench for the arithmetic decoder and its timing.
`timescale 1ns/1ps

module arith_opcode_decode_timing_tb_top;
	import arith_decode_pkg::*;

	logic       clk = 1'b0;      // Processor clock.
	logic       rst = 1'b1;      // Synchronous reset.
	logic       valid = 1'b0;    // Byte offered.
	logic [7:0] data = 8'h00;    // Offered byte.
	int         rej_seen = 0;    // Reject pulses seen so far.
	logic       ready, busy, done, reject, word, mem;
	op_e        op;
	int         err_count = 0;
	int         tests_run = 0;
	int         len;

	always #2.5 clk = ~clk;

	// Counts every reject pulse; this block is the only driver of the count.
	always @(posedge clk)
	begin
		if (reject === 1'b1)
			rej_seen <= rej_seen + 1;
	end

	arith_opcode_decode_timing u_arith_opcode_decode_timing (
		.sys_clk_i(clk), .sys_rst_i(rst), .byte_valid_i(valid),
		.byte_i(data), .byte_ready_o(ready), .busy_o(busy), .done_o(done),
		.reject_o(reject), .op_o(op), .word_o(word), .mem_o(mem));

	// ==================================================================
	// Reporting and compare tasks.
	// ==================================================================
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	task automatic miss(input string m);
		err_count++;
		$display("mismatch at %0t: %s", $time, m);
	endtask : miss
	task automatic stop(input string m);
		miss(m);
		end_sim();
	endtask : stop
	task automatic chk_int(input int g, input int e, input string m);
		tests_run++;
		if (g != e)
			miss(m);
	endtask : chk_int
	task automatic chk_bit(input logic g, input logic e, input string m);
		tests_run++;
		if (g !== e)
			miss(m);
	endtask : chk_bit
	task automatic chk_op(input op_e g, input op_e e);
		tests_run++;
		if (g !== e)
			miss("operation");
	endtask : chk_op
	// Checks that every output shows its reset value.
	task automatic chk_idle(input string m);
		chk_bit(ready, 1'b1, m);
		chk_bit(busy, 1'b0, m);
		chk_bit(done, 1'b0, m);
		chk_bit(reject, 1'b0, m);
		chk_bit(word, 1'b0, m);
		chk_bit(mem, 1'b0, m);
		chk_op(op, OP_NONE);
	endtask : chk_idle

	// ==================================================================
	// Byte stream drivers, entered and left at a falling edge.
	// ==================================================================
	task automatic send(input logic [7:0] b);
		int i;
		valid = 1'b1;
		data = b;
		for (i = 0; i < 40 && ready !== 1'b1; i++)
			@(negedge clk);
		if (i == 40)
			stop("ready never rose");
		@(negedge clk);
	endtask : send

	// Sends one instruction, offers a stray byte while busy, then judges.
	task automatic run(input logic [31:0] s, input int nb, input op_e eo,
		input int en, input logic ew, input logic em);
		int i;
		int r0;
		r0 = rej_seen;
		for (i = nb - 1; i >= 0; i--)
			send(s[8*i +: 8]);
		data = 8'h00;
		len = 0;
		for (i = 0; i < 40 && done !== 1'b1; i++)
		begin
			if (busy === 1'b1)
			begin
				len++;
				chk_bit(ready, 1'b0, "ready while busy");
			end
			@(negedge clk);
		end
		if (i == 40)
			stop("done never came");
		chk_int(len, en, "busy length");
		chk_op(op, eo);
		chk_bit(word, ew, "word size");
		chk_bit(mem, em, "memory operand");
		chk_int(rej_seen - r0, 0, "byte taken while busy");
	endtask : run

	// Sends bytes that must be refused as an unknown instruction.
	task automatic rej(input logic [15:0] s, input int nb);
		int i;
		for (i = nb - 1; i >= 0; i--)
			send(s[8*i +: 8]);
		valid = 1'b0;
		chk_bit(reject, 1'b1, "no reject");
		chk_op(op, OP_NONE);
		@(negedge clk);
		chk_bit(busy, 1'b0, "busy after reject");
	endtask : rej

	task automatic finish_test(input string name);
		valid = 1'b0;
		@(negedge clk);
		$display("test %s done", name);
	endtask : finish_test

	// ==================================================================
	// Scenarios.
	// ==================================================================
	task automatic t_reset;
		repeat (6) @(negedge clk);
		chk_idle("idle in reset");
		rst = 1'b0;
		@(negedge clk);
		chk_idle("idle after reset");
		$display("test reset done");
	endtask : t_reset

	// Back-to-back adjusts, each after the first taken in the previous done cycle.
	task automatic t_adjust;
		run(32'h37, 1, OP_UNPACKED_ADD_ADJUST, 3, 1'b0, 1'b0);
		run(32'h27, 1, OP_PACKED_ADD_ADJUST, 3, 1'b0, 1'b0);
		run(32'h3F, 1, OP_UNPACKED_SUB_ADJUST, 3, 1'b0, 1'b0);
		run(32'h2F, 1, OP_PACKED_SUB_ADJUST, 3, 1'b0, 1'b0);
		finish_test("adjust");
	endtask : t_adjust

	task automatic t_multiply;
		run(32'hF6E0, 2, OP_UNSIGNED_MULTIPLY, 13, 1'b0, 1'b0);
		run(32'hF7E0, 2, OP_UNSIGNED_MULTIPLY, 21, 1'b1, 1'b0);
		run(32'hF626, 2, OP_UNSIGNED_MULTIPLY, 16, 1'b0, 1'b1);
		run(32'hF726, 2, OP_UNSIGNED_MULTIPLY, 24, 1'b1, 1'b1);
		run(32'hF6E8, 2, OP_SIGNED_MULTIPLY, 13, 1'b0, 1'b0);
		run(32'hF7E8, 2, OP_SIGNED_MULTIPLY, 21, 1'b1, 1'b0);
		run(32'hF62E, 2, OP_SIGNED_MULTIPLY, 16, 1'b0, 1'b1);
		run(32'hF72E, 2, OP_SIGNED_MULTIPLY, 24, 1'b1, 1'b1);
		finish_test("multiply");
	endtask : t_multiply

	// Two data bytes when s is 0, one when s is 1.
	task automatic t_imm;
		run(32'h69C01234, 4, OP_SIGNED_MULTIPLY_IMM, 21, 1'b1, 1'b0);
		run(32'h6B0655, 3, OP_SIGNED_MULTIPLY_IMM, 24, 1'b1, 1'b1);
		run(32'h6BC155, 3, OP_SIGNED_MULTIPLY_IMM, 21, 1'b1, 1'b0);
		finish_test("immediate multiply");
	endtask : t_imm

	task automatic t_divide;
		run(32'hF6F0, 2, OP_UNSIGNED_DIVIDE, 14, 1'b0, 1'b0);
		run(32'hF7F0, 2, OP_UNSIGNED_DIVIDE, 22, 1'b1, 1'b0);
		run(32'hF636, 2, OP_UNSIGNED_DIVIDE, 17, 1'b0, 1'b1);
		run(32'hF736, 2, OP_UNSIGNED_DIVIDE, 25, 1'b1, 1'b1);
		finish_test("divide");
	endtask : t_divide

	// Near-miss opcodes and sub-opcodes outside the handled set.
	task automatic t_reject;
		rej(16'h36, 1);
		rej(16'hF6D8, 2);
		rej(16'h6D, 1);
		rej(16'hF7F8, 2);
		finish_test("reject");
	endtask : t_reject

	// A two-cycle reset during a multiply drops it and leaves it idle.
	task automatic t_mid_reset;
		send(8'hF7);
		send(8'hE0);
		valid = 1'b0;
		repeat (4) @(negedge clk);
		chk_bit(busy, 1'b1, "busy before reset");
		rst = 1'b1;
		repeat (2) @(negedge clk);
		chk_idle("idle in mid reset");
		rst = 1'b0;
		@(negedge clk);
		chk_idle("idle after mid reset");
		run(32'h27, 1, OP_PACKED_ADD_ADJUST, 3, 1'b0, 1'b0);
		finish_test("mid reset");
	endtask : t_mid_reset

	initial
	begin
		t_reset();
		t_adjust();
		t_multiply();
		t_imm();
		t_divide();
		t_reject();
		t_mid_reset();
		end_sim();
	end
endmodule : arith_opcode_decode_timing_tb_top
